/* File: rtl/iqr_offset_cal.sv */
// Receive back end: decimation filters, offset calibration sequencer and output buffer.
`timescale 1ns/100ps
`default_nettype none

module iqr_offset_cal (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Power control
    input wire logic rxPowerOnPin,
    input wire logic rxPowerOnBit,
    // Configuration
    input wire iqr_pkg::iqr_cfg_t cfg,
    // Host offset write
    input wire logic offsetWrite,
    input wire iqr_pkg::iqr_offset_t offsetWrData,
    // Modulator bit streams
    input wire logic modBitI,
    input wire logic modBitQ,
    // Sample stream
    output logic outValid,
    input wire logic outReady,
    output iqr_pkg::iqr_sample_t outData,
    // Status
    output iqr_pkg::iqr_offset_t offsetValue,
    output logic calShortInputs,
    output logic calBusy,
    output logic rxReady,
    output logic wordLost
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Equal-weight taps: the sum of +1/-1 samples is 2*ones - taps,
    // scaled up by 32 so full scale reaches just over half the word. The taps are not
    // shaped, so the passband corner is only approximated.
    function automatic logic signed [iqr_pkg::WORD_W-1:0] filt_word(
        input logic [iqr_pkg::ONES_W-1:0] ones
    );
        logic signed [iqr_pkg::ONES_W:0] sum;
        sum = $signed({ones, 1'b0}) - $signed(iqr_pkg::TAP_MID);
        // Widen before the shift so the upper bits are not lost.
        filt_word = iqr_pkg::WORD_W'(sum) <<< iqr_pkg::GAIN_SHIFT;
    endfunction

    // Offset lines up with word bits 3..12; result saturates so an
    // overrange offset cannot wrap the sign.
    function automatic logic [iqr_pkg::WORD_W-1:0] apply_offset(
        input logic signed [iqr_pkg::WORD_W-1:0] word,
        input logic [iqr_pkg::OFF_W-1:0] off
    );
        logic signed [iqr_pkg::WORD_W+1:0] diff;
        logic signed [iqr_pkg::WORD_W+1:0] offExt;
        offExt = (iqr_pkg::WORD_W+2)'($signed(off)) <<< iqr_pkg::OFF_SHIFT;
        diff = (iqr_pkg::WORD_W+2)'(word) - offExt;
        if (diff > (iqr_pkg::WORD_W+2)'(16'sh3fff)) begin
            apply_offset = 15'h3fff;
        end else if (diff < -(iqr_pkg::WORD_W+2)'(16'sh4000)) begin
            apply_offset = 15'h4000;
        end else begin
            apply_offset = diff[iqr_pkg::WORD_W-1:0];
        end
    endfunction

    function automatic logic [iqr_pkg::ONES_W-1:0] next_ones(
        input logic [iqr_pkg::ONES_W-1:0] ones,
        input logic newBit,
        input logic oldBit
    );
        next_ones = ones + iqr_pkg::ONES_W'(newBit) - iqr_pkg::ONES_W'(oldBit);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    iqr_pkg::iqr_regs_t r_r;
    iqr_pkg::iqr_regs_t r_nxt;

    logic rx_power_on;
    logic tick;
    logic wake;
    logic pop;
    logic push;
    logic [iqr_pkg::WORD_W-1:0] rawI;
    logic [iqr_pkg::WORD_W-1:0] rawQ;
    iqr_pkg::iqr_sample_t word;

    always_comb begin
        r_nxt = r_r;

        // Pin passes two flops; only the second is read.
        r_nxt.pinSync = {r_r.pinSync[0], rxPowerOnPin};
        rx_power_on = r_r.pinSync[1] | rxPowerOnBit;
        r_nxt.rxOnPrev = rx_power_on;
        wake = rx_power_on & ~r_r.rxOnPrev;

        // ------------------------------------------------------------
        // Bit-time tick, free running
        // ------------------------------------------------------------
        tick = (r_r.tickCnt == iqr_pkg::TICK_LAST);
        r_nxt.tickCnt = tick ? 6'h00 : r_r.tickCnt + 6'h01;

        // ------------------------------------------------------------
        // Filters: a new modulator bit every second master clock
        // ------------------------------------------------------------
        r_nxt.phase = ~r_r.phase;
        if (r_r.phase) begin
            r_nxt.tapI = {r_r.tapI[iqr_pkg::TAPS-2:0], modBitI};
            r_nxt.tapQ = {r_r.tapQ[iqr_pkg::TAPS-2:0], modBitQ};
            r_nxt.onesI = next_ones(r_r.onesI, modBitI, r_r.tapI[iqr_pkg::TAPS-1]);
            r_nxt.onesQ = next_ones(r_r.onesQ, modBitQ, r_r.tapQ[iqr_pkg::TAPS-1]);
        end
        rawI = filt_word(r_r.onesI);
        rawQ = filt_word(r_r.onesQ);
        word.i = apply_offset(rawI, r_r.offset.i);
        word.q = apply_offset(rawQ, r_r.offset.q);

        // ------------------------------------------------------------
        // Power-up sequencer
        // ------------------------------------------------------------
        if (tick && r_r.timer != 8'h00) begin
            r_nxt.timer = r_r.timer - 8'h01;
        end
        if (!rx_power_on) begin
            // Offsets and settings are left untouched while asleep.
            r_nxt.st = iqr_pkg::ST_SLEEP;
            r_nxt.shortInputs = 1'b0;
            r_nxt.calBusy = 1'b0;
        end else begin
            unique case (r_r.st)
                iqr_pkg::ST_SLEEP: begin
                    if (wake) begin
                        r_nxt.st = iqr_pkg::ST_SETTLE;
                        r_nxt.timer = iqr_pkg::SETTLE_TICKS;
                    end
                end
                iqr_pkg::ST_SETTLE: begin
                    if (r_r.timer == 8'h00) begin
                        r_nxt.st = iqr_pkg::ST_PRE;
                        r_nxt.timer = cfg.preCalDelay;
                    end
                end
                iqr_pkg::ST_PRE: begin
                    if (r_r.timer == 8'h00) begin
                        if (cfg.autoCalSelect) begin
                            r_nxt.st = iqr_pkg::ST_CAL;
                            r_nxt.calTicks = 6'h00;
                            r_nxt.accI = '0;
                            r_nxt.accQ = '0;
                            r_nxt.calBusy = 1'b1;
                            r_nxt.shortInputs = ~cfg.externalCalMode;
                        end else begin
                            r_nxt.st = iqr_pkg::ST_POST;
                            r_nxt.timer = cfg.postCalDelay;
                        end
                    end
                end
                iqr_pkg::ST_CAL: begin
                    if (tick) begin
                        r_nxt.calTicks = r_r.calTicks + 6'h01;
                        // The filter first fills with samples of the shorted or external calibration input.
                        if (r_r.calTicks >= iqr_pkg::ACC_FIRST &&
                                r_r.calTicks < iqr_pkg::ACC_DONE) begin
                            r_nxt.accI = r_r.accI + iqr_pkg::ACC_W'($signed(rawI));
                            r_nxt.accQ = r_r.accQ + iqr_pkg::ACC_W'($signed(rawQ));
                        end
                        if (r_r.calTicks == iqr_pkg::ACC_DONE) begin
                            // Average of 16, then drop the three bits below the offset.
                            r_nxt.offset.i = iqr_pkg::OFF_W'(r_r.accI >>>
                                (iqr_pkg::AVG_SHIFT + iqr_pkg::OFF_SHIFT));
                            r_nxt.offset.q = iqr_pkg::OFF_W'(r_r.accQ >>>
                                (iqr_pkg::AVG_SHIFT + iqr_pkg::OFF_SHIFT));
                            r_nxt.shortInputs = 1'b0;
                        end
                        if (r_r.calTicks == iqr_pkg::CAL_LAST) begin
                            r_nxt.st = iqr_pkg::ST_POST;
                            r_nxt.timer = cfg.postCalDelay;
                            r_nxt.calBusy = 1'b0;
                        end
                    end
                end
                iqr_pkg::ST_POST: begin
                    if (r_r.timer == 8'h00) begin
                        r_nxt.st = iqr_pkg::ST_RUN;
                    end
                end
                iqr_pkg::ST_RUN: begin
                end
                default: begin
                    r_nxt.st = iqr_pkg::ST_SLEEP;
                end
            endcase
        end

        // Host writes only count in user calibration.
        if (offsetWrite && !cfg.autoCalSelect) begin
            r_nxt.offset = offsetWrData;
        end

        r_nxt.rxReady = rx_power_on && (r_nxt.st == iqr_pkg::ST_RUN);

        // ------------------------------------------------------------
        // Two-entry output buffer
        // ------------------------------------------------------------
        // The filter cannot stall, so a word that finds the buffer full
        // is dropped and flagged until the next sleep.
        pop = (r_r.count != 2'h0) && outReady;
        push = tick && (r_r.st == iqr_pkg::ST_RUN) && rx_power_on;
        if (pop) begin
            r_nxt.buf0 = r_r.buf1;
            r_nxt.count = r_r.count - 2'h1;
        end
        if (push) begin
            if (r_nxt.count == 2'h0) begin
                r_nxt.buf0 = word;
                r_nxt.count = 2'h1;
            end else if (r_nxt.count == 2'h1) begin
                r_nxt.buf1 = word;
                r_nxt.count = 2'h2;
            end else begin
                r_nxt.wordLost = 1'b1;
            end
        end
        if (!rx_power_on) begin
            r_nxt.count = 2'h0;
            r_nxt.wordLost = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r_r <= '0;
            r_r.st <= iqr_pkg::ST_SLEEP;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign outValid = (r_r.count != 2'h0);
    assign outData = r_r.buf0;
    assign offsetValue = r_r.offset;
    assign calShortInputs = r_r.shortInputs;
    assign calBusy = r_r.calBusy;
    assign rxReady = r_r.rxReady;
    assign wordLost = r_r.wordLost;

endmodule

`default_nettype wire

/* File: rtl/iqr_pkg.sv */
// Constants, states and carriers of the I/Q receive offset calibration block.
//
// Contract
// - Each modulator bit stream is sampled on every second master clock cycle.
// - I and Q words leave as 15-bit two's complement values.
// - Each channel uses a 288-tap FIR clocked at half the master clock.
// - The filter passband corner sits at 96 kHz.
// - Words are invalid until all 288 taps hold post-change samples.
// - The stored offset is subtracted from the filter output before leaving.
// - Offset is 10-bit two's complement, aligned to word bits 3 to 12.
// - With autocalibration selected, every wake from sleep starts a calibration.
// - After power-on, wait 36 symbol periods, then time the pre-calibration delay.
// - Calibrate only when autocalibration is selected, otherwise skip that phase.
// - Internal mode shorts the inputs while measuring; external keeps pins connected.
// - Calibration averages 16 measurements per channel into the offset value.
// - Calibration window, settling included, lasts 40 times 48 master cycles.
// - Pre and post delays run 0 to 255 bit times each.
// - Valid words start exactly when the post-calibration delay expires; here rxReady rises then and the first word follows on the next bit-time tick.
// - In user calibration the host writes offsets and owns all offset correction.
// - Offsets and settings stay valid while the receive path sleeps.
// - User mode outputs its first pair only after analog and filter settling.
// - Autocalibration select 1 means auto, 0 user; external mode when set.
package iqr_pkg;

    // ----------------------------------------------------------------
    // Filter and word format
    // ----------------------------------------------------------------
    localparam int TAPS = 288;
    localparam int WORD_W = 15;
    localparam int OFF_W = 10;
    localparam int OFF_SHIFT = 3;
    localparam int ONES_W = 9;
    localparam int GAIN_SHIFT = 5;
    localparam logic [ONES_W:0] TAP_MID = 10'h120;

    // ----------------------------------------------------------------
    // Timing, counted in master clocks and bit-time ticks
    // ----------------------------------------------------------------
    localparam int TICK_CYCLES = 48;
    localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
    localparam logic [7:0] SETTLE_TICKS = 8'h24;
    localparam int CAL_TICKS = 40;
    localparam int CAL_SAMPLES = 16;
    localparam int AVG_SHIFT = 4;
    localparam int FILT_SETTLE_TICKS = (TAPS * 2 + TICK_CYCLES - 1) / TICK_CYCLES;
    localparam logic [5:0] ACC_FIRST = 6'(FILT_SETTLE_TICKS);
    localparam logic [5:0] ACC_DONE = 6'(FILT_SETTLE_TICKS + CAL_SAMPLES);
    localparam logic [5:0] CAL_LAST = 6'(CAL_TICKS - 1);
    localparam int ACC_W = WORD_W + AVG_SHIFT;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_SLEEP  = 6'h01,
        ST_SETTLE = 6'h02,
        ST_PRE    = 6'h04,
        ST_CAL    = 6'h08,
        ST_POST   = 6'h10,
        ST_RUN    = 6'h20
    } iqr_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0] i;
        logic [WORD_W-1:0] q;
    } iqr_sample_t;

    typedef struct packed {
        logic autoCalSelect;
        logic externalCalMode;
        logic [7:0] preCalDelay;
        logic [7:0] postCalDelay;
    } iqr_cfg_t;

    typedef struct packed {
        logic [OFF_W-1:0] i;
        logic [OFF_W-1:0] q;
    } iqr_offset_t;

    typedef struct packed {
        iqr_state_t st;
        logic [1:0] pinSync;
        logic rxOnPrev;
        logic phase;
        logic [5:0] tickCnt;
        logic [7:0] timer;
        logic [5:0] calTicks;
        logic [TAPS-1:0] tapI;
        logic [TAPS-1:0] tapQ;
        logic [ONES_W-1:0] onesI;
        logic [ONES_W-1:0] onesQ;
        logic signed [ACC_W-1:0] accI;
        logic signed [ACC_W-1:0] accQ;
        iqr_offset_t offset;
        iqr_sample_t buf0;
        iqr_sample_t buf1;
        logic [1:0] count;
        logic shortInputs;
        logic calBusy;
        logic rxReady;
        logic wordLost;
    } iqr_regs_t;

endpackage

/* File: tb/iqr_dsp_model.sv */
// Sample reader standing in for the DSP on the stream side.
`timescale 1ns/100ps
`default_nettype none

module iqr_dsp_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Stream
    input wire logic outValid,
    input wire iqr_pkg::iqr_sample_t outData,
    output logic outReady,
    // Bench control and capture
    input wire logic stall,
    output iqr_pkg::iqr_sample_t lastWord,
    output logic [15:0] wordCount
);
    // Ready is registered, so a stall takes effect one edge late, as a real reader would.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            outReady <= 1'b0;
            lastWord <= '0;
            wordCount <= 16'h0000;
        end else begin
            outReady <= !stall;
            if (outValid && outReady) begin
                lastWord <= outData;
                wordCount <= wordCount + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/iqr_offset_cal_chk.sv */
// Checker for the I/Q receive offset calibration block.
`timescale 1ns/100ps
`default_nettype none

module iqr_offset_cal_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Block inputs
    input wire logic rxPowerOnPin,
    input wire logic rxPowerOnBit,
    input wire iqr_pkg::iqr_cfg_t cfg,
    input wire logic offsetWrite,
    input wire iqr_pkg::iqr_offset_t offsetWrData,
    input wire logic outReady,
    // Block outputs
    input wire logic outValid,
    input wire iqr_pkg::iqr_sample_t outData,
    input wire iqr_pkg::iqr_offset_t offsetValue,
    input wire logic calShortInputs,
    input wire logic calBusy,
    input wire logic rxReady
);
    // ------
    // Helper counters
    // ------
    // The tick runs free, so the window may slip by a cycle or two.
    localparam int CAL_MIN = 1918;
    localparam int CAL_MAX = 1922;
    localparam int SETTLE_MIN = 1680;
    logic [11:0] busyCnt;
    logic [15:0] onCnt;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busyCnt <= 12'h000;
            onCnt <= 16'h0000;
        end else begin
            busyCnt <= calBusy ? busyCnt + 12'h001 : 12'h000;
            if (!(rxPowerOnBit || rxPowerOnPin))
                onCnt <= 16'h0000;
            else if (onCnt != 16'hffff)
                onCnt <= onCnt + 16'h0001;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence offSeq;
        (!rxPowerOnBit && !rxPowerOnPin) [*4];
    endsequence
    sequence stallSeq;
        outValid && !outReady && rxPowerOnBit && !rxPowerOnPin;
    endsequence

    power_off_a: assert property (offSeq |-> !rxReady && !outValid && !calBusy)
        else $error("outputs active while powered off");
    hold_word_a: assert property (stallSeq |=> outValid && $stable(outData))
        else $error("held word changed under stall");
    cal_len_a: assert property ($fell(calBusy) |-> busyCnt >= CAL_MIN && busyCnt <= CAL_MAX)
        else $error("calibration window length wrong");
    cal_auto_a: assert property ($rose(calBusy) |-> cfg.autoCalSelect)
        else $error("calibration without auto select");
    short_int_a: assert property (calShortInputs |-> calBusy && !cfg.externalCalMode)
        else $error("inputs shorted outside internal calibration");
    short_start_a: assert property ($rose(calBusy) |-> calShortInputs == !cfg.externalCalMode)
        else $error("short control wrong at calibration start");
    user_wr_a: assert property (offsetWrite && !cfg.autoCalSelect |=> offsetValue == $past(offsetWrData))
        else $error("host offset write lost");
    auto_ref_a: assert property (offsetWrite && cfg.autoCalSelect && !calBusy |=> $stable(offsetValue))
        else $error("host offset write taken in auto mode");
    settle_a: assert property ($rose(rxReady) |-> onCnt >= SETTLE_MIN)
        else $error("words before settling time");
    word_run_a: assert property ($rose(outValid) |-> $past(rxReady))
        else $error("word outside run state");
    offset_keep_a: assert property (!calBusy && !offsetWrite |=> $stable(offsetValue))
        else $error("offset changed without a write");
endmodule

bind iqr_offset_cal iqr_offset_cal_chk chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .rxPowerOnPin(rxPowerOnPin),
    .rxPowerOnBit(rxPowerOnBit),
    .cfg(cfg),
    .offsetWrite(offsetWrite),
    .offsetWrData(offsetWrData),
    .outReady(outReady),
    .outValid(outValid),
    .outData(outData),
    .offsetValue(offsetValue),
    .calShortInputs(calShortInputs),
    .calBusy(calBusy),
    .rxReady(rxReady)
);
`default_nettype wire

/* File: tb/iqr_offset_cal_tb_top.sv */
// Testbench for the I/Q receive offset calibration block.
`timescale 1ns/100ps
`default_nettype none

module iqr_offset_cal_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic rxPowerOnPin = 1'b0;
    logic rxPowerOnBit = 1'b0;
    logic offsetWrite = 1'b0;
    logic modBitI = 1'b1;
    logic modBitQ = 1'b0;
    logic tglMode = 1'b0;
    logic stall = 1'b0;
    logic [1:0] tgl = 2'h0;
    iqr_pkg::iqr_cfg_t cfg = '0;
    iqr_pkg::iqr_offset_t offsetWrData = '0;
    iqr_pkg::iqr_offset_t offsetValue;
    iqr_pkg::iqr_sample_t outData;
    iqr_pkg::iqr_sample_t lastWord;
    logic outValid, outReady, calShortInputs, calBusy, rxReady, wordLost;
    logic [15:0] wordCount;
    int failCount = 0;
    int numChecks = 0;

    always #4 sys_clk = ~sys_clk;

    // A bit pattern flipping every two cycles gives alternate samples, so zero mean.
    always @(posedge sys_clk) begin
        tgl <= tgl + 2'h1;
        if (tglMode) begin
            modBitI <= tgl[1];
            modBitQ <= tgl[1];
        end
    end

    iqr_offset_cal uut (.sys_clk(sys_clk), .rst(rst), .rxPowerOnPin(rxPowerOnPin),
        .rxPowerOnBit(rxPowerOnBit), .cfg(cfg), .offsetWrite(offsetWrite),
        .offsetWrData(offsetWrData), .modBitI(modBitI), .modBitQ(modBitQ),
        .outValid(outValid), .outReady(outReady), .outData(outData),
        .offsetValue(offsetValue), .calShortInputs(calShortInputs), .calBusy(calBusy),
        .rxReady(rxReady), .wordLost(wordLost));
    iqr_dsp_model dsp (.sys_clk(sys_clk), .rst(rst), .outValid(outValid), .outData(outData),
        .outReady(outReady), .stall(stall), .lastWord(lastWord), .wordCount(wordCount));

    task report_and_stop;
        if (failCount == 0 && numChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk_data(input logic [29:0] got, input logic [29:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_flag(input logic got, input logic exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_until(ref logic s, input logic lvl);
        int n;
        n = 0;
        while (s !== lvl && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic next_word;
        logic [15:0] w;
        int n;
        w = wordCount;
        n = 0;
        while (wordCount === w && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task wr_off(input iqr_pkg::iqr_offset_t v);
        @(posedge sys_clk);
        offsetWrite <= 1'b1;
        offsetWrData <= v;
        @(posedge sys_clk);
        offsetWrite <= 1'b0;
        @(negedge sys_clk);
    endtask

    // Ticks run free, so the total may slip by up to two ticks.
    task automatic power_up(input logic au, input logic ex, input logic [7:0] pre,
        input logic [7:0] post, input logic usePin, input int ticks);
        int n;
        @(posedge sys_clk);
        cfg <= '{au, ex, pre, post};
        if (usePin)
            rxPowerOnPin <= 1'b1;
        else
            rxPowerOnBit <= 1'b1;
        n = 0;
        while (rxReady !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        chk_flag(n >= ticks * 48 - 96 && n <= ticks * 48 + 96, 1'b1);
    endtask

    task power_down;
        @(posedge sys_clk);
        rxPowerOnBit <= 1'b0;
        rxPowerOnPin <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk_flag(rxReady, 1'b0);
        chk_flag(wordLost, 1'b0);
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        failCount++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        wr_off('{10'h010, 10'h3f0});
        chk_data(30'(offsetValue), 30'h000043f0);
        power_up(1'b0, 1'b0, 8'h14, 8'h0a, 1'b0, 66);
        next_word;
        chk_data(lastWord, {15'h2380, 15'h5c80});
        stall <= 1'b1;
        wait_until(wordLost, 1'b1);
        chk_flag(wordLost, 1'b1);
        chk_flag(outValid, 1'b1);
        chk_data(outData, {15'h2380, 15'h5c80});
        @(posedge sys_clk);
        stall <= 1'b0;
        wait_until(outValid, 1'b0);
        chk_flag(outValid, 1'b0);
        power_down;
        chk_data(30'(offsetValue), 30'h000043f0);
        @(posedge sys_clk);
        cfg.autoCalSelect <= 1'b1;
        tglMode <= 1'b1;
        wr_off('{10'h155, 10'h0aa});
        chk_data(30'(offsetValue), 30'h000043f0);
        power_up(1'b1, 1'b0, 8'h00, 8'h00, 1'b0, 76);
        chk_data(30'(offsetValue), 30'h00000000);
        next_word;
        chk_data(lastWord, 30'h00000000);
        power_down;
        wr_off('{10'h155, 10'h0aa});
        power_up(1'b1, 1'b1, 8'h03, 8'h02, 1'b1, 81);
        chk_data(30'(offsetValue), 30'h00000000);
        report_and_stop;
    end
endmodule
`default_nettype wire
